// ### src/thermistor_profile_pkg.sv
// Purpose: Shared constants and types for the thermistor profile configuration bank.
// Assumes: Registers are reached over an 8-bit serial control register port.
// Notes:   Temperatures are signed whole degrees Celsius in two's complement.
package thermistor_profile_pkg;

  localparam logic [7:0] ADDR_CONTROL_A   = 8'h1A;
  localparam logic [7:0] ADDR_THRESHOLDS  = 8'h1B;
  localparam logic [7:0] ADDR_CONTROL_C   = 8'h1C;

  localparam logic [7:0] RESET_CONTROL_A  = 8'h3D;
  localparam logic [7:0] RESET_THRESHOLDS = 8'h25;
  localparam logic [7:0] RESET_CONTROL_C  = 8'h3F;
  localparam logic [7:0] WRITE_MASK_C     = 8'h7F;

  localparam int OVERRIDE_BIT    = 7;
  localparam int HOT_LIMIT_LSB   = 5;
  localparam int COLD_LIMIT_BIT  = 4;
  localparam int WARM_CUR_LSB    = 2;
  localparam int COOL_CUR_LSB    = 0;
  localparam int LOW_SET_LSB     = 5;
  localparam int HIGH_SET_LSB    = 2;
  localparam int WARM_VOLT_LSB   = 0;
  localparam int MIRROR_BIT      = 6;
  localparam int PREWARM_VOLT_LSB = 4;
  localparam int PREWARM_CUR_LSB = 2;
  localparam int PRECOOL_CUR_LSB = 0;

  localparam int SENSE_WIDTH     = 5;

  localparam logic [1:0] CODE_SUSPEND   = 2'h0;
  localparam logic [1:0] CODE_UNCHANGED = 2'h3;
  localparam logic [1:0] HOT_LIMIT_OFF  = 2'h3;

  typedef enum logic [2:0] {
    zone_in_range = 3'h0,
    cool_zone     = 3'h1,
    precool_zone  = 3'h2,
    prewarm_zone  = 3'h3,
    warm_zone     = 3'h4,
    hot_zone      = 3'h5,
    cold_zone     = 3'h6
  } zone_t;

  localparam logic [7:0] TH1_TABLE [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                              8'hFB, 8'hFB, 8'hFB, 8'h00};
  localparam logic [7:0] TH2_TABLE [0:7] = '{8'h05, 8'h0A, 8'h0F, 8'h14,
                                              8'h05, 8'h0A, 8'h0A, 8'h0A};
  localparam logic [7:0] TH3_TABLE [0:7] = '{8'h0F, 8'h0F, 8'h14, 8'h14,
                                              8'h0F, 8'h0F, 8'h14, 8'h14};
  localparam logic [7:0] TH4_TABLE [0:7] = '{8'h23, 8'h23, 8'h23, 8'h28,
                                              8'h23, 8'h23, 8'h28, 8'h28};
  localparam logic [7:0] TH5_TABLE [0:7] = '{8'h28, 8'h2D, 8'h32, 8'h37,
                                              8'h28, 8'h2D, 8'h2D, 8'h32};
  localparam logic [7:0] TH6_TABLE [0:7] = '{8'h3C, 8'h3C, 8'h3C, 8'h3C,
                                              8'h32, 8'h32, 8'h3C, 8'h3C};
  localparam logic [7:0] HOT_TABLE [0:3] = '{8'h37, 8'h3C, 8'h41, 8'h00};
  localparam logic [7:0] COLD_TABLE [0:1] = '{8'hEC, 8'hF6};

endpackage : thermistor_profile_pkg

// ### src/zone_policy_if.sv
// Purpose: Carries configuration fields to the zone policy and its answer back.
// Assumes: Both ends run on the same clock.
// Notes:   Purely combinational signals.
`timescale 1ns/1ps
`default_nettype none
interface zone_policy_if;
  thermistor_profile_pkg::zone_t zone;
  logic [1:0]                    warm_cur;
  logic [1:0]                    cool_cur;
  logic [1:0]                    prewarm_cur;
  logic [1:0]                    precool_cur;
  logic [1:0]                    warm_volt;
  logic [1:0]                    prewarm_volt;
  logic                          mirror;
  logic [1:0]                    cur_sel;
  logic [1:0]                    volt_sel;
  logic                          charge_en;

  modport bank (output zone, warm_cur, cool_cur, prewarm_cur, precool_cur, warm_volt,
                output prewarm_volt, mirror, input cur_sel, volt_sel, charge_en);
  modport policy (input zone, warm_cur, cool_cur, prewarm_cur, precool_cur, warm_volt,
                  input prewarm_volt, mirror, output cur_sel, volt_sel, charge_en);
endinterface : zone_policy_if
`default_nettype wire

// ### src/zone_policy.sv
// Purpose: Picks the charge current and voltage adjustment codes for the current zone.
// Assumes: The zone given is already forced to in-range when feedback is overridden.
// Notes:   No state; the bank registers the answer.
`timescale 1ns/1ps
`default_nettype none
module zone_policy
(
  zone_policy_if.policy pif
);

  always_comb
  begin
    pif.cur_sel  = thermistor_profile_pkg::CODE_UNCHANGED;
    pif.volt_sel = thermistor_profile_pkg::CODE_UNCHANGED;
    unique case (pif.zone)
      thermistor_profile_pkg::zone_in_range:
      begin
        pif.cur_sel  = thermistor_profile_pkg::CODE_UNCHANGED;
      end
      thermistor_profile_pkg::warm_zone:
      begin
        pif.cur_sel  = pif.warm_cur;
        pif.volt_sel = pif.warm_volt;
      end
      thermistor_profile_pkg::cool_zone:
      begin
        pif.cur_sel  = pif.cool_cur;
        pif.volt_sel = pif.mirror ? pif.warm_volt
                                  : thermistor_profile_pkg::CODE_UNCHANGED;
      end
      thermistor_profile_pkg::prewarm_zone:
      begin
        pif.cur_sel  = pif.prewarm_cur;
        pif.volt_sel = pif.prewarm_volt;
      end
      thermistor_profile_pkg::precool_zone:
      begin
        pif.cur_sel  = pif.precool_cur;
        pif.volt_sel = pif.mirror ? pif.prewarm_volt
                                  : thermistor_profile_pkg::CODE_UNCHANGED;
      end
      // Hot and cold stop charging outright regardless of the zone fields.
      thermistor_profile_pkg::hot_zone,
      thermistor_profile_pkg::cold_zone:
      begin
        pif.cur_sel  = thermistor_profile_pkg::CODE_SUSPEND;
      end
      default:
      begin
        pif.cur_sel  = thermistor_profile_pkg::CODE_SUSPEND;
      end
    endcase
    pif.charge_en = (pif.cur_sel != thermistor_profile_pkg::CODE_SUSPEND);
  end

endmodule : zone_policy
`default_nettype wire

// ### src/thermistor_profile_config.sv
// Purpose: Thermistor temperature profile configuration bank and its zone policy outputs.
// Assumes: Register port strobes come from the serial control logic on clk.
// Notes:   Zone and boost comparator inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module thermistor_profile_config
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_reset,
  input  wire logic       watchdog_expired,
  input  wire logic [2:0] zone_sense,
  input  wire logic       boost_hot_trip,
  input  wire logic       boost_cold_trip,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic      [2:0] thermistor_zone_report,
  output logic      [1:0] charge_current_sel,
  output logic      [1:0] charge_voltage_sel,
  output logic            charge_enable,
  output logic            boost_enable,
  output logic      [7:0] th1_temp,
  output logic      [7:0] th2_temp,
  output logic      [7:0] th3_temp,
  output logic      [7:0] th4_temp,
  output logic      [7:0] th5_temp,
  output logic      [7:0] th6_temp,
  output logic      [7:0] boost_hot_temp,
  output logic            boost_hot_enable,
  output logic      [7:0] boost_cold_temp
);

  localparam int SW = thermistor_profile_pkg::SENSE_WIDTH;

  typedef struct packed {
    logic [7:0]    control_a;
    logic [7:0]    thresholds;
    logic [7:0]    control_c;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] sense;
    logic [7:0]    rdata;
    logic          rvalid;
    logic [2:0]    zone_rep;
    logic [1:0]    cur_sel;
    logic [1:0]    volt_sel;
    logic          charge_en;
    logic          boost_en;
    logic [7:0]    th1;
    logic [7:0]    th2;
    logic [7:0]    th3;
    logic [7:0]    th4;
    logic [7:0]    th5;
    logic [7:0]    th6;
    logic [7:0]    hot_temp;
    logic          hot_en;
    logic [7:0]    cold_temp;
  } state_t;

  state_t                        st;
  state_t                        next_st;
  zone_policy_if                 pif ();
  thermistor_profile_pkg::zone_t sensed_zone;
  logic                          override;
  logic [1:0]                    hot_code;
  logic                          cold_code;
  logic [2:0]                    low_code;
  logic [2:0]                    high_code;

  assign override  = st.control_a[thermistor_profile_pkg::OVERRIDE_BIT];
  assign hot_code  = st.control_a[thermistor_profile_pkg::HOT_LIMIT_LSB +: 2];
  assign cold_code = st.control_a[thermistor_profile_pkg::COLD_LIMIT_BIT];
  assign low_code  = st.thresholds[thermistor_profile_pkg::LOW_SET_LSB +: 3];
  assign high_code = st.thresholds[thermistor_profile_pkg::HIGH_SET_LSB +: 3];

  // An unknown comparator pattern is treated as cold so charging stays stopped.
  always_comb
  begin
    if (st.sense[2:0] > 3'h6)
    begin
      sensed_zone = thermistor_profile_pkg::cold_zone;
    end
    else
    begin
      sensed_zone = thermistor_profile_pkg::zone_t'(st.sense[2:0]);
    end
  end

  assign pif.zone         = override ? thermistor_profile_pkg::zone_in_range
                                     : sensed_zone;
  assign pif.warm_cur     = st.control_a[thermistor_profile_pkg::WARM_CUR_LSB +: 2];
  assign pif.cool_cur     = st.control_a[thermistor_profile_pkg::COOL_CUR_LSB +: 2];
  assign pif.warm_volt    = st.thresholds[thermistor_profile_pkg::WARM_VOLT_LSB +: 2];
  assign pif.mirror       = st.control_c[thermistor_profile_pkg::MIRROR_BIT];
  assign pif.prewarm_volt = st.control_c[thermistor_profile_pkg::PREWARM_VOLT_LSB +: 2];
  assign pif.prewarm_cur  = st.control_c[thermistor_profile_pkg::PREWARM_CUR_LSB +: 2];
  assign pif.precool_cur  = st.control_c[thermistor_profile_pkg::PRECOOL_CUR_LSB +: 2];

  zone_policy policy_inst
  (
    .pif (pif.policy)
  );

  always_comb
  begin
    next_st = st;

    // A change on a sensed input counts only once the last two stages agree.
    next_st.sync1 = {boost_cold_trip, boost_hot_trip, zone_sense};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < SW; i++)
    begin
      if (st.sync2[i] == st.sync3[i])
      begin
        next_st.sense[i] = st.sync3[i];
      end
    end

    // Register writes; reserved bit of the third register is never stored.
    if (reg_wr)
    begin
      unique case (reg_addr)
        thermistor_profile_pkg::ADDR_CONTROL_A:
        begin
          next_st.control_a = reg_wdata;
        end
        thermistor_profile_pkg::ADDR_THRESHOLDS:
        begin
          next_st.thresholds = reg_wdata;
        end
        thermistor_profile_pkg::ADDR_CONTROL_C:
        begin
          next_st.control_c = reg_wdata & thermistor_profile_pkg::WRITE_MASK_C;
        end
        default:
        begin
          next_st.control_a = st.control_a;
        end
      endcase
    end

    // Watchdog expiry beats a write of the override bit in the same cycle.
    if (watchdog_expired)
    begin
      next_st.control_a[thermistor_profile_pkg::OVERRIDE_BIT] = 1'b0;
    end

    if (reg_reset)
    begin
      next_st.control_a  = thermistor_profile_pkg::RESET_CONTROL_A;
      next_st.thresholds = thermistor_profile_pkg::RESET_THRESHOLDS;
      next_st.control_c  = thermistor_profile_pkg::RESET_CONTROL_C;
    end

    // Reads return the stored value before any write in the same cycle.
    next_st.rvalid = reg_rd;
    if (reg_rd)
    begin
      unique case (reg_addr)
        thermistor_profile_pkg::ADDR_CONTROL_A:
        begin
          next_st.rdata = st.control_a;
        end
        thermistor_profile_pkg::ADDR_THRESHOLDS:
        begin
          next_st.rdata = st.thresholds;
        end
        thermistor_profile_pkg::ADDR_CONTROL_C:
        begin
          next_st.rdata = st.control_c & thermistor_profile_pkg::WRITE_MASK_C;
        end
        default:
        begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    next_st.zone_rep  = pif.zone;
    next_st.cur_sel   = pif.cur_sel;
    next_st.volt_sel  = pif.volt_sel;
    next_st.charge_en = pif.charge_en;

    next_st.hot_temp  = thermistor_profile_pkg::HOT_TABLE[hot_code];
    next_st.hot_en    = (hot_code != thermistor_profile_pkg::HOT_LIMIT_OFF);
    next_st.cold_temp = thermistor_profile_pkg::COLD_TABLE[cold_code];

    // Boost stops on a hot trip only while the hot limit is enabled.
    next_st.boost_en  = override |
                        (~(st.hot_en & st.sense[3]) & ~st.sense[4]);

    next_st.th1 = thermistor_profile_pkg::TH1_TABLE[low_code];
    next_st.th2 = thermistor_profile_pkg::TH2_TABLE[low_code];
    next_st.th3 = thermistor_profile_pkg::TH3_TABLE[low_code];
    next_st.th4 = thermistor_profile_pkg::TH4_TABLE[high_code];
    next_st.th5 = thermistor_profile_pkg::TH5_TABLE[high_code];
    next_st.th6 = thermistor_profile_pkg::TH6_TABLE[high_code];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st            <= '0;
      st.control_a  <= thermistor_profile_pkg::RESET_CONTROL_A;
      st.thresholds <= thermistor_profile_pkg::RESET_THRESHOLDS;
      st.control_c  <= thermistor_profile_pkg::RESET_CONTROL_C;
      st.cur_sel    <= thermistor_profile_pkg::CODE_UNCHANGED;
      st.volt_sel   <= thermistor_profile_pkg::CODE_UNCHANGED;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign reg_rdata              = st.rdata;
  assign reg_rvalid             = st.rvalid;
  assign thermistor_zone_report = st.zone_rep;
  assign charge_current_sel     = st.cur_sel;
  assign charge_voltage_sel     = st.volt_sel;
  assign charge_enable          = st.charge_en;
  assign boost_enable           = st.boost_en;
  assign th1_temp               = st.th1;
  assign th2_temp               = st.th2;
  assign th3_temp               = st.th3;
  assign th4_temp               = st.th4;
  assign th5_temp               = st.th5;
  assign th6_temp               = st.th6;
  assign boost_hot_temp         = st.hot_temp;
  assign boost_hot_enable       = st.hot_en;
  assign boost_cold_temp        = st.cold_temp;

endmodule : thermistor_profile_config
`default_nettype wire

// ### sim/thermistor_profile_config_assertions.sv
// Purpose: Port-level checks of the thermistor profile bank.
// Assumes: A shadow of the three registers follows host writes and resets.
// Notes:   Derived outputs trail the registers by one edge, so a delayed shadow is used.
`timescale 1ns/1ps
`default_nettype none
module thermistor_profile_config_assertions
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_reset,
  input wire logic       watchdog_expired,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [2:0] thermistor_zone_report,
  input wire logic [1:0] charge_current_sel,
  input wire logic [1:0] charge_voltage_sel,
  input wire logic       charge_enable,
  input wire logic       boost_enable,
  input wire logic [7:0] th1_temp,
  input wire logic [7:0] th2_temp,
  input wire logic [7:0] th3_temp,
  input wire logic [7:0] th4_temp,
  input wire logic [7:0] th5_temp,
  input wire logic [7:0] th6_temp,
  input wire logic [7:0] boost_hot_temp,
  input wire logic       boost_hot_enable,
  input wire logic [7:0] boost_cold_temp
);
  logic [7:0] ra, rb, rc, pa, pb, pc, pr;
  logic       live;
  always_ff @(posedge clk)
  begin
    live <= !srst;
    pa   <= ra;
    pb   <= rb;
    pc   <= rc;
    pr   <= reg_addr == 8'h1A ? ra : reg_addr == 8'h1B ? rb : reg_addr == 8'h1C ? rc : 8'h00;
    if (srst || (ce && reg_reset))
    begin
      ra <= 8'h3D;
      rb <= 8'h25;
      rc <= 8'h3F;
    end
    else if (ce)
    begin
      if (reg_wr && reg_addr == 8'h1A)
        ra <= reg_wdata;
      if (reg_wr && reg_addr == 8'h1B)
        rb <= reg_wdata;
      if (reg_wr && reg_addr == 8'h1C)
        rc <= {1'b0, reg_wdata[6:0]};
      // The watchdog clear wins over a write of the same bit.
      if (watchdog_expired)
        ra[7] <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_override;
    live && pa[7] |-> thermistor_zone_report == 3'h0 && charge_current_sel == 2'h3 && boost_enable;
  endproperty
  a_override: assert property (p_override) else $error("override not applied");
  property p_hot;
    live |-> boost_hot_temp == thermistor_profile_pkg::HOT_TABLE[pa[6:5]]
             && boost_hot_enable == (pa[6:5] != 2'h3);
  endproperty
  a_hot: assert property (p_hot) else $error("hot limit wrong");
  property p_cold;
    live |-> boost_cold_temp == thermistor_profile_pkg::COLD_TABLE[pa[4]];
  endproperty
  a_cold: assert property (p_cold) else $error("cold limit wrong");
  property p_low;
    live |-> th1_temp == thermistor_profile_pkg::TH1_TABLE[pb[7:5]]
             && th2_temp == thermistor_profile_pkg::TH2_TABLE[pb[7:5]]
             && th3_temp == thermistor_profile_pkg::TH3_TABLE[pb[7:5]];
  endproperty
  a_low: assert property (p_low) else $error("low thresholds wrong");
  property p_high;
    live |-> th4_temp == thermistor_profile_pkg::TH4_TABLE[pb[4:2]]
             && th5_temp == thermistor_profile_pkg::TH5_TABLE[pb[4:2]]
             && th6_temp == thermistor_profile_pkg::TH6_TABLE[pb[4:2]];
  endproperty
  a_high: assert property (p_high) else $error("high thresholds wrong");
  property p_warm_cur;
    live && thermistor_zone_report == 3'h4 |-> charge_current_sel == pa[3:2]
                                                 && charge_enable == (pa[3:2] != 2'h0);
  endproperty
  a_warm_cur: assert property (p_warm_cur) else $error("warm current wrong");
  property p_cool_cur;
    live && thermistor_zone_report == 3'h1 |-> charge_current_sel == pa[1:0];
  endproperty
  a_cool_cur: assert property (p_cool_cur) else $error("cool current wrong");
  property p_warm_volt;
    live && thermistor_zone_report == 3'h4 |-> charge_voltage_sel == pb[1:0];
  endproperty
  a_warm_volt: assert property (p_warm_volt) else $error("warm voltage wrong");
  property p_mirror;
    live && thermistor_zone_report == 3'h1 |-> charge_voltage_sel == (pc[6] ? pb[1:0] : 2'h3);
  endproperty
  a_mirror: assert property (p_mirror) else $error("cool voltage wrong");
  property p_prewarm;
    live && thermistor_zone_report == 3'h3 |-> charge_current_sel == pc[3:2]
             && charge_voltage_sel == pc[5:4];
  endproperty
  a_prewarm: assert property (p_prewarm) else $error("prewarm settings wrong");
  property p_precool;
    live && thermistor_zone_report == 3'h2 |-> charge_current_sel == pc[1:0]
             && charge_voltage_sel == (pc[6] ? pc[5:4] : 2'h3);
  endproperty
  a_precool: assert property (p_precool) else $error("precool settings wrong");
  property p_read;
    live && ce && reg_rd |=> reg_rvalid && reg_rdata == pr;
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  c_override: cover property (live && pa[7]);
  c_warm_off: cover property (thermistor_zone_report == 3'h4 && !charge_enable);
  c_mirror: cover property (thermistor_zone_report == 3'h1 && pc[6]);
endmodule : thermistor_profile_config_assertions
`default_nettype wire

// ### sim/host_model.sv
// Purpose: Host controller on the register port.
// Assumes: A request is taken at the first rising edge after it is raised.
// Notes:   Idle lines carry the inverse of the last value, so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input  wire logic       clk,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hFF;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    ok = 1'b0;
    d  = 8'h00;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      #1;
      if (reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d  = reg_rdata;
      end
      else
        @(posedge clk);
    end
  endtask : rd
endmodule : host_model
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the thermistor profile bank.
// Assumes: Clock enable is held high throughout.
// Notes:   Register contents are tracked in a shadow built from the field rules.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        reg_reset = 1'b0;
  logic        watchdog_expired = 1'b0;
  logic [2:0]  zone_sense = 3'h0;
  logic        boost_hot_trip = 1'b0;
  logic        boost_cold_trip = 1'b0;
  logic        reg_wr, reg_rd, reg_rvalid, charge_enable, boost_enable, boost_hot_enable;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, boost_hot_temp, boost_cold_temp;
  logic [7:0]  th1_temp, th2_temp, th3_temp, th4_temp, th5_temp, th6_temp;
  logic [2:0]  thermistor_zone_report;
  logic [1:0]  charge_current_sel, charge_voltage_sel;
  logic [7:0]  shadow [3];
  logic [15:0] seed = 16'h63FE;
  int          err_total = 0;
  int          compares = 0;
  always #4 clk = ~clk;
  thermistor_profile_config DUT (.clk, .srst, .ce(1'b1), .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_reset, .watchdog_expired, .zone_sense, .boost_hot_trip, .boost_cold_trip, .reg_rdata,
    .reg_rvalid, .thermistor_zone_report, .charge_current_sel, .charge_voltage_sel,
    .charge_enable, .boost_enable, .th1_temp, .th2_temp, .th3_temp, .th4_temp, .th5_temp,
    .th6_temp, .boost_hot_temp, .boost_hot_enable, .boost_cold_temp);
  host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] expect_read(input logic [7:0] a);
    return (a inside {8'h1A, 8'h1B, 8'h1C}) ? shadow[a - 8'h1A] : 8'h00;
  endfunction : expect_read
  task automatic conclude;
    $display("Compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    // The reserved top bit of the third register never holds a one.
    if (a == 8'h1C)
      shadow[2] = {1'b0, d[6:0]};
    else if (a inside {8'h1A, 8'h1B})
      shadow[a - 8'h1A] = d;
  endtask : write
  task automatic read_check(input logic [7:0] a);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    if (!ok)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t no read answer", $time);
      conclude();
    end
    check(d, expect_read(a));
  endtask : read_check
  task automatic sense(input logic [2:0] z, input logic hot);
    @(posedge clk);
    zone_sense      <= z;
    boost_hot_trip  <= hot;
    boost_cold_trip <= 1'b0;
  endtask : sense
  // Waits out the input synchroniser and filter.
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask : settle
  task automatic pulse_reset;
    @(posedge clk);
    reg_reset <= 1'b1;
    @(posedge clk);
    reg_reset <= 1'b0;
    shadow = '{8'h3D, 8'h25, 8'h3F};
  endtask : pulse_reset
  initial
  begin
    shadow = '{8'h3D, 8'h25, 8'h3F};
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int a = 'h1A; a <= 'h1D; a++)
      read_check(8'(a));
    check(th2_temp, 8'h0A);
    check(th5_temp, 8'h2D);
    check(boost_hot_temp, 8'h3C);
    check(boost_cold_temp, 8'hF6);
    for (int i = 0; i < 60; i++)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      zone_sense      <= seed[2:0];
      boost_hot_trip  <= seed[3];
      boost_cold_trip <= seed[4];
      write(8'h1A + {6'h0, seed[6:5]}, seed[15:8]);
      read_check(8'h1A + {6'h0, seed[6:5]});
    end
    write(8'h1A, 8'h31);
    sense(3'h4, 1'b1);
    settle();
    check({5'h0, thermistor_zone_report}, 8'h04);
    check({7'h0, charge_enable}, 8'h00);
    check({7'h0, boost_enable}, 8'h00);
    write(8'h1A, 8'hB1);
    settle();
    check({3'h0, thermistor_zone_report, charge_enable, boost_enable}, 8'h03);
    write(8'h1A, 8'h7D);
    write(8'h1B, 8'h26);
    settle();
    check({4'h0, charge_current_sel, charge_voltage_sel}, 8'h0E);
    check({7'h0, boost_enable}, 8'h01);
    @(posedge clk);
    boost_cold_trip <= 1'b1;
    settle();
    check({7'h0, boost_enable}, 8'h00);
    write(8'h1C, 8'hC0);
    sense(3'h1, 1'b0);
    settle();
    check({4'h0, charge_current_sel, charge_voltage_sel}, 8'h06);
    read_check(8'h1C);
    write(8'h1C, 8'hE9);
    sense(3'h2, 1'b0);
    settle();
    check({4'h0, charge_current_sel, charge_voltage_sel}, 8'h06);
    sense(3'h3, 1'b0);
    settle();
    check({4'h0, charge_current_sel, charge_voltage_sel}, 8'h0A);
    write(8'h1A, 8'hFF);
    @(posedge clk);
    watchdog_expired <= 1'b1;
    @(posedge clk);
    watchdog_expired <= 1'b0;
    shadow[0][7] = 1'b0;
    read_check(8'h1A);
    pulse_reset();
    for (int a = 'h1A; a <= 'h1C; a++)
      read_check(8'(a));
    conclude();
  end
endmodule : tb_top
bind thermistor_profile_config thermistor_profile_config_assertions u_chk (.clk, .srst, .ce,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_reset, .watchdog_expired, .reg_rdata,
  .reg_rvalid, .thermistor_zone_report, .charge_current_sel, .charge_voltage_sel,
  .charge_enable, .boost_enable, .th1_temp, .th2_temp, .th3_temp, .th4_temp, .th5_temp,
  .th6_temp, .boost_hot_temp, .boost_hot_enable, .boost_cold_temp);
`default_nettype wire
